// >>> smsp_pkg.sv
package smsp_pkg;

	// fifo geometry
	localparam int unsigned FIFO_W = 16;
	localparam int unsigned FIFO_D = 16;

	// register offsets
	localparam logic [7:0] OFS_DATA = 8'h00;
	localparam logic [7:0] OFS_IER = 8'h04;
	localparam logic [7:0] OFS_FCR = 8'h08;
	localparam logic [7:0] OFS_FW = 8'h0C;
	localparam logic [7:0] OFS_DLY = 8'h10;
	localparam logic [7:0] OFS_TXC = 8'h14;
	localparam logic [7:0] OFS_RXC = 8'h18;
	localparam logic [7:0] OFS_SS = 8'h1C;
	localparam logic [7:0] OFS_ISR = 8'h20;

	// fifo control fields
	localparam int FCR_RXLVL = 11;
	localparam int FCR_TXLVL = 8;
	localparam int FCR_CLR = 2;

	// flow control fields and reset value
	localparam int FW_SRST = 11;
	localparam int FW_EN = 10;
	localparam int FW_RUN = 9;
	localparam int FW_IDLE = 8;
	localparam int FW_CONC = 5;
	localparam int FW_CPOL = 4;
	localparam int FW_CPHA = 3;
	localparam int FW_LSB = 2;
	localparam int FW_BIDIR = 1;
	localparam int FW_LOOP = 0;
	localparam logic [31:0] FW_RST = 32'h0000_0100;

	// gap delay fields
	localparam int DLY_TURN = 8;
	localparam int DLY_CONS = 3;
	localparam int DLY_LEAD = 0;

	// select and character fields
	localparam int SS_CHL = 11;
	localparam int SS_SEL = 8;
	localparam int SS_DIV = 0;

	// internal fifo / soft reset length in pclk cycles
	localparam logic [1:0] RST_CYCLES = 2'h3;

	// transaction sequencer states
	typedef enum logic [5:0] {
		ST_IDLE = 6'h01,
		ST_LEAD = 6'h02,
		ST_LOAD = 6'h04,
		ST_SHIFT = 6'h08,
		ST_GAP = 6'h10,
		ST_FINISH = 6'h20
	} smsp_state_e;

	// trigger code to entry count, reserved codes act as six
	function automatic logic [4:0] trig_level(input logic [2:0] code);
		return (code == 3'h0) ? 5'h02 : (code == 3'h1) ? 5'h04 : 5'h06;
	endfunction

	// delay code to serial half periods
	function automatic logic [9:0] delay_halves(input logic [2:0] code, input logic lead);
		if (code == 3'h0) begin
			return lead ? 10'h001 : 10'h000;
		end
		return 10'h004 << code;
	endfunction

	// bit position within a character for a given bit index
	function automatic logic [3:0] bit_pos(input logic [4:0] idx, input logic [4:0] nbits, input logic lsb);
		return lsb ? idx[3:0] : 4'(nbits - 5'h01 - idx);
	endfunction

endpackage

// >>> smsp_fifo.sv
module smsp_fifo
	import smsp_pkg::*;
#(
	parameter int unsigned W = 16,
	parameter int unsigned D = 16
) (
	// clock and clear
	input wire logic clk,
	input wire logic rst_n,
	input wire logic clr,
	// fill side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [W-1:0] in_data,
	// drain side
	output logic out_valid,
	input wire logic out_ready,
	output logic [W-1:0] out_data,
	// occupancy
	output logic [$clog2(D):0] level
);
	localparam int AW = $clog2(D);

	logic [W-1:0] mem [D];
	logic [AW-1:0] wr_r;
	logic [AW-1:0] rd_r;
	logic [AW:0] cnt_r;

	// handshake and status
	assign in_ready = cnt_r != (AW+1)'(D);
	assign out_valid = cnt_r != '0;
	assign out_data = mem[rd_r];
	assign level = cnt_r;
	wire logic push = in_valid & in_ready;
	wire logic pop = out_valid & out_ready;

	// pointer advance with wrap at depth
	function automatic logic [AW-1:0] inc(input logic [AW-1:0] p);
		return (p == AW'(D - 1)) ? '0 : AW'(p + 1'b1);
	endfunction

	// storage
	always_ff @(posedge clk) begin
		if (push) begin
			mem[wr_r] <= in_data;
		end
	end

	// pointers and count
	always_ff @(posedge clk) begin
		if (!rst_n || clr) begin
			wr_r <= '0;
			rd_r <= '0;
			cnt_r <= '0;
		end else begin
			if (push) wr_r <= inc(wr_r);
			if (pop) rd_r <= inc(rd_r);
			cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule // smsp_fifo

// >>> smsp_clkdiv.sv
module smsp_clkdiv
	import smsp_pkg::*;
(
	// clock and control
	input wire logic clk,
	input wire logic rst_n,
	input wire logic clr,
	input wire logic [5:0] div,
	// half period enable
	output logic tick
);
	logic [5:0] cnt_r;

	// one pulse every div+1 pclk cycles
	assign tick = (cnt_r == div) & ~clr;

	always_ff @(posedge clk) begin
		if (!rst_n || clr || tick) begin
			cnt_r <= 6'h00;
		end else begin
			cnt_r <= cnt_r + 6'h01;
		end
	end
endmodule // smsp_clkdiv

// >>> smsp_master.sv
// Overview of operation
// - offset zero pushes tx, pops rx
// - trigger codes mean two, four, six entries
// - fifo control shows tx full, rx available
// - fifo reset lasts three cycles, accesses ignored
// - soft reset bit resets logic three cycles
// - enable bit turns controller on
// - run rise starts; hardware clears at end
// - clock may idle on fifo stall
// - concurrent bit lets tx and rx overlap
// - polarity bit sets idle clock level
// - phase bit picks first or second edge
// - low bit first selects bit order
// - bidirectional bit shares the data line
// - loopback bit feeds output to input
// - tx to rx gap in clock periods
// - gap between consecutive transfers
// - lead delay from select to clock
// - counters set transfers, zero stops
// - character length is code plus one, four bits for codes below three
// - select field drives one select low
// - divisor field sets bit rate
// - trigger flags follow fifo levels, interrupt
// - overrun flag keeps fifo, cleared by clear
// - receive complete flag cleared on read
module smsp_master
	import smsp_pkg::*;
(
	// clock and reset
	input wire logic CLK,
	input wire logic RST_N,
	// register port
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [7:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	// serial link
	output logic SCLK,
	output logic [7:0] SS_N,
	output logic MOSI_O,
	output logic MOSI_OE,
	input wire logic MOSI_I,
	input wire logic MISO,
	// interrupt
	output logic IRQ
);

	// register state
	logic [3:0] ier_r;
	logic [2:0] fcr_rx_r;
	logic [2:0] fcr_tx_r;
	logic en_r;
	logic run_r;
	logic idle_r;
	logic [5:0] mode_r;
	logic [10:0] dly_r;
	logic [15:0] txc_r;
	logic [15:0] rxc_r;
	logic [14:0] ss_r;
	logic ovr_r;
	logic rxc_flag_r;
	logic [1:0] frst_cnt_r;
	logic soft_r;

	// engine state
	smsp_state_e state_r;
	smsp_state_e state_nxt;
	logic [9:0] gap_r;
	logic [9:0] gap_nxt;
	logic rx_phase_r;
	logic word_tx_r;
	logic word_rx_r;
	logic rx_did_r;
	logic [5:0] edge_r;
	logic [15:0] tx_word_r;
	logic [15:0] rx_word_r;
	logic [15:0] rx_word_nxt;
	logic arm_r;
	logic miso_s1_r;
	logic miso_s2_r;
	logic mosi_s1_r;
	logic mosi_s2_r;

	// fifo and divider wires
	logic tx_in_ready;
	logic tx_out_valid;
	logic [15:0] tx_dout;
	logic [4:0] tx_level;
	logic rx_in_ready;
	logic rx_out_valid;
	logic [15:0] rx_dout;
	logic [4:0] rx_level;
	logic tick;

	// bus phase and address decode
	wire logic wr_acc = PSEL & PENABLE & PWRITE;
	wire logic rd_set = PSEL & ~PENABLE & ~PWRITE;
	wire logic sel_data = PADDR == OFS_DATA;
	wire logic sel_ier = PADDR == OFS_IER;
	wire logic sel_fcr = PADDR == OFS_FCR;
	wire logic sel_fw = PADDR == OFS_FW;
	wire logic sel_dly = PADDR == OFS_DLY;
	wire logic sel_txc = PADDR == OFS_TXC;
	wire logic sel_rxc = PADDR == OFS_RXC;
	wire logic sel_ss = PADDR == OFS_SS;
	wire logic sel_isr = PADDR == OFS_ISR;

	// configuration fields
	wire logic conc = mode_r[FW_CONC];
	wire logic cpol = mode_r[FW_CPOL];
	wire logic cpha = mode_r[FW_CPHA];
	wire logic lsb = mode_r[FW_LSB];
	wire logic bidir = mode_r[FW_BIDIR];
	wire logic loopb = mode_r[FW_LOOP];
	wire logic [3:0] chl = ss_r[SS_CHL +: 4];
	wire logic [2:0] ssel = ss_r[SS_SEL +: 3];
	wire logic [5:0] cdiv = ss_r[SS_DIV +: 6];
	wire logic [9:0] lead_halves = delay_halves(dly_r[DLY_LEAD +: 3], 1'b1);
	wire logic [9:0] cons_halves = delay_halves(dly_r[DLY_CONS +: 3], 1'b0);
	wire logic [9:0] turn_halves = delay_halves(dly_r[DLY_TURN +: 3], 1'b0);
	wire logic [4:0] nbits = (chl < 4'h3) ? 5'h04 : 5'(chl) + 5'h01;

	// internal resets
	wire logic fifo_busy = frst_cnt_r != 2'h0;
	wire logic ctl_busy = soft_r;
	wire logic soft_req = wr_acc & sel_fw & PWDATA[FW_SRST];
	wire logic fclr_req = wr_acc & sel_fcr & PWDATA[FCR_CLR];

	// state decode
	wire logic st_idle = state_r == ST_IDLE;
	wire logic st_lead = state_r == ST_LEAD;
	wire logic st_load = state_r == ST_LOAD;
	wire logic st_shift = state_r == ST_SHIFT;
	wire logic st_gap = state_r == ST_GAP;
	wire logic st_finish = state_r == ST_FINISH;

	// word scheduling in the load state
	wire logic want_tx = (txc_r != 16'h0000) & (conc | ~rx_phase_r);
	wire logic want_rx = (rxc_r != 16'h0000) & (conc | rx_phase_r);
	wire logic turn = ~conc & ~rx_phase_r & (txc_r == 16'h0000) & (rxc_r != 16'h0000);
	wire logic all_done = (txc_r == 16'h0000) & (rxc_r == 16'h0000);
	wire logic stall = idle_r & ((want_tx & ~tx_out_valid) | (want_rx & ~rx_in_ready));
	wire logic load_go = st_load & ~all_done & ~turn & ~stall;
	wire logic tx_pop = load_go & want_tx & ~fifo_busy;

	// bit timing within a character
	wire logic last_edge = edge_r == 6'({nbits, 1'b0} - 6'h01);
	wire logic word_done = st_shift & tick & last_edge;
	wire logic sample_now = st_shift & tick & (edge_r[0] == cpha);
	wire logic [3:0] pos = bit_pos(edge_r[5:1], nbits, lsb);
	wire logic out_bit = tx_word_r[pos];
	wire logic in_bit = loopb ? out_bit : (bidir ? mosi_s2_r : miso_s2_r);

	// fifo handshakes from the bus and the engine
	wire logic tx_push = wr_acc & sel_data & ~fifo_busy;
	wire logic rx_pop = rd_set & sel_data & ~fifo_busy;
	wire logic rx_push = word_done & word_rx_r & ~fifo_busy;
	wire logic ovr_set = word_done & word_rx_r & ~rx_in_ready;

	// status flags
	wire logic tx_lvl_flag = (5'(FIFO_D) - tx_level) >= trig_level(fcr_tx_r);
	wire logic rx_lvl_flag = rx_level >= trig_level(fcr_rx_r);
	wire logic [3:0] isr = {tx_lvl_flag, rx_lvl_flag, ovr_r, rxc_flag_r};
	wire logic [7:0] ss_dec = 8'(8'h01 << ssel);
	wire logic link_act = st_lead | st_load | st_shift | st_gap;

	// read data selection
	wire logic [31:0] rd_mux =
		sel_data ? {16'h0000, rx_out_valid ? rx_dout : 16'h0000} :
		sel_ier ? {28'h000_0000, ier_r} :
		sel_fcr ? {18'h0_0000, fcr_rx_r, fcr_tx_r, 6'h00, ~tx_in_ready, rx_out_valid} :
		sel_fw ? {20'h0_0000, 1'b0, en_r, run_r, idle_r, 2'h0, mode_r} :
		sel_dly ? {21'h00_0000, dly_r[10:8], 2'h0, dly_r[5:0]} :
		sel_txc ? {16'h0000, txc_r} :
		sel_rxc ? {16'h0000, rxc_r} :
		sel_ss ? {17'h0_0000, ss_r} :
		sel_isr ? {28'h000_0000, isr} : 32'h0000_0000;

	// fifos and bit clock divider
	smsp_fifo #(.W(FIFO_W), .D(FIFO_D)) u_txf (
		.clk(CLK), .rst_n(RST_N), .clr(fifo_busy),
		.in_valid(tx_push), .in_ready(tx_in_ready), .in_data(PWDATA[15:0]),
		.out_valid(tx_out_valid), .out_ready(tx_pop), .out_data(tx_dout),
		.level(tx_level)
	);

	smsp_fifo #(.W(FIFO_W), .D(FIFO_D)) u_rxf (
		.clk(CLK), .rst_n(RST_N), .clr(fifo_busy),
		.in_valid(rx_push), .in_ready(rx_in_ready), .in_data(rx_word_nxt),
		.out_valid(rx_out_valid), .out_ready(rx_pop), .out_data(rx_dout),
		.level(rx_level)
	);

	smsp_clkdiv u_div (
		.clk(CLK), .rst_n(RST_N),
		.clr(~(st_lead | st_gap | (st_shift & arm_r))),
		.div(cdiv), .tick(tick)
	);

	// configuration registers
	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			ier_r <= 4'h0;
			fcr_rx_r <= 3'h0;
			fcr_tx_r <= 3'h0;
			en_r <= FW_RST[FW_EN];
			idle_r <= FW_RST[FW_IDLE];
			mode_r <= FW_RST[5:0];
			dly_r <= 11'h000;
			ss_r <= 15'h0000;
		end else if (wr_acc) begin
			if (sel_ier) ier_r <= PWDATA[3:0];
			if (sel_fcr) fcr_rx_r <= PWDATA[FCR_RXLVL +: 3];
			if (sel_fcr) fcr_tx_r <= PWDATA[FCR_TXLVL +: 3];
			if (sel_fw) en_r <= PWDATA[FW_EN];
			if (sel_fw) idle_r <= PWDATA[FW_IDLE];
			if (sel_fw) mode_r <= PWDATA[5:0];
			if (sel_dly) dly_r <= {PWDATA[10:8], 2'h0, PWDATA[5:0]};
			if (sel_ss) ss_r <= {PWDATA[14:8], 2'h0, PWDATA[5:0]};
		end
	end

	// three cycle fifo / soft reset window
	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			frst_cnt_r <= 2'h0;
			soft_r <= 1'b0;
		end else if (soft_req || fclr_req) begin
			frst_cnt_r <= RST_CYCLES;
			soft_r <= soft_req | soft_r;
		end else if (fifo_busy) begin
			frst_cnt_r <= frst_cnt_r - 2'h1;
			soft_r <= soft_r & (frst_cnt_r != 2'h1);
		end
	end

	// run bit: software rise starts, hardware clears at end
	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			run_r <= 1'b0;
		end else if (wr_acc && sel_fw && PWDATA[FW_RUN] && PWDATA[FW_EN] && !run_r && !ctl_busy) begin
			run_r <= 1'b1;
		end else if (st_finish || !en_r || ctl_busy) begin
			run_r <= 1'b0;
		end
	end

	// transfer counters: software write wins over decrement
	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			txc_r <= 16'h0000;
			rxc_r <= 16'h0000;
		end else begin
			if (wr_acc && sel_txc) txc_r <= PWDATA[15:0];
			else if (word_done && word_tx_r && txc_r != 16'h0000) txc_r <= txc_r - 16'h0001;
			if (wr_acc && sel_rxc) rxc_r <= PWDATA[15:0];
			else if (word_done && word_rx_r && rxc_r != 16'h0000) rxc_r <= rxc_r - 16'h0001;
		end
	end

	// sticky flags, set wins over clear
	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			ovr_r <= 1'b0;
			rxc_flag_r <= 1'b0;
		end else begin
			ovr_r <= ovr_set | (ovr_r & ~fifo_busy);
			rxc_flag_r <= (st_finish & rx_did_r) | (rxc_flag_r & ~(rd_set & sel_isr) & ~ctl_busy);
		end
	end

	// sequencer next state
	always_comb begin
		state_nxt = state_r;
		gap_nxt = gap_r;
		unique case (state_r)
			ST_IDLE: begin
				if (run_r) begin
					state_nxt = ST_LEAD;
					gap_nxt = lead_halves;
				end
			end
			ST_LEAD, ST_GAP: begin
				if (tick) begin
					if (gap_r <= 10'h001) state_nxt = ST_LOAD;
					else gap_nxt = gap_r - 10'h001;
				end
			end
			ST_LOAD: begin
				if (all_done) begin
					state_nxt = ST_FINISH;
				end else if (turn) begin
					if (turn_halves != 10'h000) begin
						state_nxt = ST_GAP;
						gap_nxt = turn_halves;
					end
				end else if (!stall) begin
					state_nxt = ST_SHIFT;
				end
			end
			ST_SHIFT: begin
				if (word_done) begin
					if (cons_halves != 10'h000) begin
						state_nxt = ST_GAP;
						gap_nxt = cons_halves;
					end else begin
						state_nxt = ST_LOAD;
					end
				end
			end
			ST_FINISH: state_nxt = ST_IDLE;
			default: state_nxt = ST_IDLE;
		endcase
		if (!en_r || ctl_busy) state_nxt = ST_IDLE;
	end

	// sequencer state
	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			state_r <= ST_IDLE;
			gap_r <= 10'h000;
			arm_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			gap_r <= gap_nxt;
			arm_r <= st_shift & ~word_done;
		end
	end

	// receive assembly
	always_comb begin
		rx_word_nxt = rx_word_r;
		if (sample_now) rx_word_nxt[pos] = in_bit;
	end

	// word registers and phase tracking
	always_ff @(posedge CLK) begin
		if (!RST_N || ctl_busy) begin
			rx_phase_r <= 1'b0;
			word_tx_r <= 1'b0;
			word_rx_r <= 1'b0;
			rx_did_r <= 1'b0;
			edge_r <= 6'h00;
			tx_word_r <= 16'h0000;
			rx_word_r <= 16'h0000;
		end else begin
			if (st_idle) rx_phase_r <= 1'b0;
			if (st_idle) rx_did_r <= 1'b0;
			if (st_load && turn) rx_phase_r <= 1'b1;
			if (load_go) begin
				word_tx_r <= want_tx;
				word_rx_r <= want_rx;
				rx_did_r <= rx_did_r | want_rx;
				tx_word_r <= (tx_pop && tx_out_valid) ? tx_dout : 16'h0000;
				rx_word_r <= 16'h0000;
				edge_r <= 6'h00;
			end else if (st_shift) begin
				rx_word_r <= rx_word_nxt;
				if (tick) edge_r <= edge_r + 6'h01;
			end
		end
	end

	// input synchronisers
	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			miso_s1_r <= 1'b0;
			miso_s2_r <= 1'b0;
			mosi_s1_r <= 1'b0;
			mosi_s2_r <= 1'b0;
		end else begin
			miso_s1_r <= MISO;
			miso_s2_r <= miso_s1_r;
			mosi_s1_r <= MOSI_I;
			mosi_s2_r <= mosi_s1_r;
		end
	end

	// link outputs
	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			SCLK <= 1'b0;
			SS_N <= 8'hFF;
			MOSI_O <= 1'b0;
			MOSI_OE <= 1'b1;
		end else begin
			SCLK <= (st_shift && tick) ? ~SCLK : (st_shift ? SCLK : cpol);
			SS_N <= link_act ? ~ss_dec : 8'hFF;
			MOSI_O <= st_shift & out_bit;
			MOSI_OE <= ~bidir | (st_shift & word_tx_r);
		end
	end

	// bus read data and interrupt
	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			PRDATA <= 32'h0000_0000;
			IRQ <= 1'b0;
		end else begin
			if (rd_set) PRDATA <= rd_mux;
			IRQ <= (isr & ier_r) != 4'h0;
		end
	end

	// checks
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RST_N);

	ss_one_hot_a: assert property (link_act |=> (SS_N == ~ss_dec))
		else $error("slave select does not match field");
	idle_polarity_a: assert property (st_idle && $past(st_idle) && $stable(cpol) |=> SCLK == $past(cpol))
		else $error("idle clock level wrong");
	run_clears_a: assert property (st_finish |=> !run_r && st_idle)
		else $error("run bit not cleared at end");
	fifo_rst_len_a: assert property ($rose(fifo_busy) && !soft_req && !fclr_req |-> fifo_busy[*3] ##1 !fifo_busy)
		else $error("fifo reset not three cycles");
	soft_rst_len_a: assert property ($rose(ctl_busy) |-> ctl_busy[*3])
		else $error("soft reset too short");
	disable_idle_a: assert property (!en_r && !(wr_acc && sel_fw) |=> st_idle && !run_r)
		else $error("disabled controller not idle");
	no_idle_stall_a: assert property (!idle_r && en_r && !ctl_busy && st_load && !all_done && !turn |=> st_shift)
		else $error("clock idled while not allowed");
	no_overlap_a: assert property (st_shift && !conc |-> !(word_tx_r && word_rx_r))
		else $error("tx and rx overlapped");
	lsb_first_a: assert property (st_shift && arm_r && lsb && edge_r == 6'h00 |-> MOSI_O == tx_word_r[0])
		else $error("bit order wrong");
	overrun_set_a: assert property (word_done && word_rx_r && !rx_in_ready && !rx_pop && !fifo_busy |=> ovr_r && !rx_in_ready)
		else $error("overrun not flagged or fifo lost");
	rx_complete_a: assert property (st_finish && rx_did_r |=> rxc_flag_r)
		else $error("receive complete not flagged");
	lead_gap_a: assert property ($rose(st_lead) && dly_r[2:0] == 3'h0 |-> st_lead until_with (tick || !en_r || ctl_busy))
		else $error("lead state left early");
	loop_input_a: assert property (word_done && loopb && word_rx_r && word_tx_r |-> rx_word_nxt == (tx_word_r & 16'((17'h0_0001 << nbits) - 17'h0_0001)))
		else $error("loopback sample wrong");

	cover_cpha1_word: cover property (word_done && cpha && word_tx_r);
	cover_bidir_rx: cover property (word_done && bidir && word_rx_r && !word_tx_r);
	cover_overrun: cover property (ovr_set);
	cover_stall: cover property (st_load && stall ##1 st_load ##1 st_shift);
endmodule // smsp_master

// >>> smsp_slave_model.sv
// behavioural peripheral on the far side of the serial link
module smsp_slave_model (
	// link pins
	input wire logic sclk,
	input wire logic ss_n,
	input wire logic mosi,
	output logic miso,
	// mode as programmed into the master
	input wire logic cpol,
	input wire logic cpha,
	input wire logic lsb,
	input wire logic [4:0] nbits
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [15:0] tx_q[$];
	logic [15:0] rx_q[$];
	logic [15:0] out_w;
	logic [15:0] in_w;
	int idx;

	// bit position of the idx-th bit on the wire
	function automatic int pos(input int i);
		return lsb ? i : nbits - 1 - i;
	endfunction

	// next word to send, zero once the host ran out of words
	function automatic logic [15:0] next_word();
		return (tx_q.size() > 0) ? tx_q.pop_front() : 16'h0000;
	endfunction

	// start of frame: with phase 0 the first bit must be ready before the first edge
	always @(negedge ss_n) begin
		idx = 0;
		in_w = 16'h0000;
		out_w = next_word();
		if (!cpha) begin
			miso = out_w[pos(0)];
		end
	end

	// released line carries no holder, so show the inverse of the last bit
	always @(posedge ss_n) begin
		miso = ~miso;
	end

	// sampling and shifting edges, chosen from polarity and phase
	always @(sclk) begin
		if (ss_n === 1'b0) begin
			if ((sclk != cpol) ^ cpha) begin
				in_w[pos(idx)] = mosi;
				idx++;
				if (idx == nbits) begin
					rx_q.push_back(in_w);
					in_w = 16'h0000;
					idx = 0;
					out_w = next_word();
				end
			end else begin
				miso = out_w[pos(idx)];
			end
		end
	end

	// idle level before the first frame
	initial begin
		miso = 1'b0;
	end
endmodule // smsp_slave_model

// >>> smsp_master_tb_top.sv
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin num_errors++; $display("BAD %0t: got %h exp %h", $time, (g), (e)); end end

module smsp_master_tb_top
	import smsp_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic CLK, RST_N, PSEL, PENABLE, PWRITE, SCLK, MOSI_O, MOSI_OE, IRQ;
	logic [7:0] PADDR, SS_N;
	logic [31:0] PWDATA, PRDATA, rv;
	logic [5:0] md;
	logic [4:0] nb;
	logic [2:0] sel;
	logic miso_w, data_line;
	int num_errors = 0;
	int checked = 0;
	int cyc_cnt = 0;
	int seed = 32'h0000_EAC4;
	logic [7:0] ofs [10] = '{OFS_DATA, OFS_IER, OFS_FCR, OFS_FW, OFS_DLY, OFS_TXC, OFS_RXC, OFS_SS, OFS_ISR, 8'h24};
	logic [7:0] rw_a [5] = '{OFS_IER, OFS_DLY, OFS_TXC, OFS_RXC, OFS_SS};
	logic [31:0] rw_m [5] = '{32'h0000_000F, 32'h0000_073F, 32'h0000_FFFF, 32'h0000_FFFF, 32'h0000_7F3F};

	// shared data line: master drives while enabled, else the peripheral
	assign data_line = MOSI_OE ? MOSI_O : miso_w;

	// device under test and its peripheral
	smsp_master dut_u (.CLK(CLK), .RST_N(RST_N), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
		.PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .SCLK(SCLK), .SS_N(SS_N), .MOSI_O(MOSI_O),
		.MOSI_OE(MOSI_OE), .MOSI_I(data_line), .MISO(miso_w), .IRQ(IRQ));
	smsp_slave_model slave_u (.sclk(SCLK), .ss_n(SS_N[sel]), .mosi(data_line), .miso(miso_w),
		.cpol(md[4]), .cpha(md[3]), .lsb(md[2]), .nbits(nb));

	// 125 MHz clock
	initial begin
		CLK = 1'b0;
		forever #4 CLK = ~CLK;
	end

	// verdict and end of run
	task automatic close_out;
		$display("mismatches %0d comparisons %0d", num_errors, checked);
		if (num_errors == 0 && checked > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	// hang guard
	always @(posedge CLK) begin
		cyc_cnt++;
		if (cyc_cnt == 60000) begin
			num_errors++;
			close_out();
		end
	end

	// one register access: setup, access, release
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
		@(posedge CLK);
		PSEL <= 1'b1;
		PENABLE <= 1'b0;
		PWRITE <= w;
		PADDR <= a;
		PWDATA <= d;
		@(posedge CLK);
		PENABLE <= 1'b1;
		@(posedge CLK);
		r = PRDATA;
		PSEL <= 1'b0;
		PENABLE <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		apb(1'b1, a, d, r);
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] r;
		apb(1'b0, a, 32'h0000_0000, r);
		`CHK(r, e)
	endtask

	// one transaction against the peripheral, with expectations from the model queues
	task automatic xfer(input logic [5:0] fw, input logic [3:0] chl, input logic [2:0] sl, input logic [10:0] dly,
		input int ntx, input int nrx);
		logic [15:0] m;
		logic [15:0] txw[$];
		logic [15:0] exp_rx[$];
		int cyc, lead, off;
		md = fw;
		nb = chl + 5'h01;
		sel = sl;
		m = 16'((32'h0000_0001 << nb) - 1);
		off = fw[5] ? 0 : ntx;
		slave_u.tx_q.delete();
		slave_u.rx_q.delete();
		for (int i = 0; i < ntx + nrx; i++) begin
			slave_u.tx_q.push_back(16'($random(seed)));
		end
		for (int i = 0; i < ntx; i++) begin
			txw.push_back(16'($random(seed)));
			wr(OFS_DATA, {16'h0000, txw[i]});
		end
		for (int i = 0; i < nrx; i++) begin
			exp_rx.push_back((fw[0] ? txw[i] : slave_u.tx_q[off + i]) & m);
		end
		wr(OFS_SS, (32'(chl) << SS_CHL) | (32'(sl) << SS_SEL) | 32'h0000_0003);
		wr(OFS_DLY, 32'(dly));
		wr(OFS_TXC, 32'(ntx));
		wr(OFS_RXC, 32'(nrx));
		wr(OFS_FW, 32'h0000_0500 | 32'(fw));
		wr(OFS_FW, 32'h0000_0700 | 32'(fw));
		cyc = 0;
		while (SS_N === 8'hFF && cyc < 100) begin
			@(posedge CLK);
			cyc++;
		end
		`CHK(SS_N, ~(8'h01 << sl))
		lead = (dly[2:0] == 3'h0) ? 4 : (16 << dly[2:0]);
		cyc = 0;
		while (SCLK === fw[4] && cyc < 3000) begin
			@(posedge CLK);
			cyc++;
		end
		`CHK(cyc >= lead && cyc <= lead + 6, 1'b1)
		cyc = 0;
		while (SS_N !== 8'hFF && cyc < 20000) begin
			@(posedge CLK);
			cyc++;
		end
		repeat (4) @(posedge CLK);
		rd_chk(OFS_FW, 32'h0000_0500 | 32'(fw));
		wr(OFS_IER, 32'h0000_0001);
		repeat (3) @(posedge CLK);
		`CHK(IRQ, 1'b1)
		wr(OFS_IER, 32'h0000_0000);
		rd_chk(OFS_ISR, {28'h000_0000, 1'b1, nrx >= 2, 2'b01});
		rd_chk(OFS_ISR, {28'h000_0000, 1'b1, nrx >= 2, 2'b00});
		rd_chk(OFS_FCR, 32'h0000_0001);
		for (int i = 0; i < nrx; i++) begin
			rd_chk(OFS_DATA, {16'h0000, exp_rx[i]});
		end
		rd_chk(OFS_FCR, 32'h0000_0000);
		for (int i = 0; i < ntx && !fw[0]; i++) begin
			`CHK(slave_u.rx_q[i] & m, txw[i] & m)
		end
	endtask

	// main sequence
	initial begin
		RST_N = 1'b0;
		PSEL = 1'b0;
		PENABLE = 1'b0;
		PWRITE = 1'b0;
		PADDR = 8'h00;
		PWDATA = 32'h0000_0000;
		md = 6'h00;
		nb = 5'h08;
		sel = 3'h0;
		repeat (2) @(posedge CLK);
		RST_N <= 1'b1;
		// reset values, empty receive read and an unmapped place
		for (int i = 0; i < 10; i++) begin
			rd_chk(ofs[i], (ofs[i] == OFS_FW) ? FW_RST : (ofs[i] == OFS_ISR) ? 32'h0000_0008 : 32'h0000_0000);
		end
		// read-write fields keep what is written, reserved bits read zero
		for (int i = 0; i < 5; i++) begin
			rv = $random(seed);
			wr(rw_a[i], rv);
			rd_chk(rw_a[i], rv & rw_m[i]);
			wr(rw_a[i], 32'h0000_0000);
		end
		wr(8'h24, $random(seed));
		rd_chk(8'h24, 32'h0000_0000);
		// transmit trigger codes against fill level, each pass starting from a cleared fifo
		for (int c = 0; c < 4; c++) begin
			wr(OFS_FCR, (32'(c) << FCR_TXLVL) | 32'h0000_0004);
			repeat (2) @(posedge CLK);
			for (int k = 1; k <= 16; k++) begin
				wr(OFS_DATA, $random(seed));
				apb(1'b0, OFS_ISR, 32'h0000_0000, rv);
				`CHK(rv[3], ((16 - k) >= (c == 0 ? 2 : c == 1 ? 4 : 6)))
			end
		end
		rd_chk(OFS_FCR, 32'h0000_0302);
		wr(OFS_DATA, $random(seed));
		wr(OFS_FW, 32'h0000_0900);
		repeat (4) @(posedge CLK);
		rd_chk(OFS_FCR, 32'h0000_0300);
		rd_chk(OFS_FW, FW_RST);
		wr(OFS_FCR, 32'h0000_0000);
		// transfers across modes, lengths, selects and gaps
		xfer(6'b100000, 4'h7, 3'h0, 11'h000, 2, 2);
		xfer(6'b011100, 4'hB, 3'h5, 11'h109, 1, 2);
		xfer(6'b000010, 4'hF, 3'h7, 11'h000, 1, 1);
		xfer(6'b100001, 4'h3, 3'h2, 11'h000, 2, 2);
		// run rise while disabled starts nothing
		wr(OFS_TXC, 32'h0000_0001);
		wr(OFS_FW, 32'h0000_0200);
		repeat (20) @(posedge CLK);
		`CHK(SS_N, 8'hFF)
		close_out();
	end
endmodule // smsp_master_tb_top
